// *** rtl/lpm_defs.svh ***
// Summary of operation
// - Wait mode stops CPU clock, halting CPU, watchdog and shutdown-input filter.
// - With count source protection set, watchdog keeps counting in wait mode.
// - Oscillators keep running in wait mode; clocked peripherals keep working.
// - Gate bit set stops main peripheral clock in wait; other clocks unaffected.
// - Stop mode halts all oscillators, CPU clock and all peripheral clocks.
// - Externally driven peripheral functions keep operating in stop mode.
// - All I/O port states are held through wait and stop mode.
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

// ==========================================================
// Register offsets
`define OFS_CLK_CTRL0 8'h00
`define OFS_CSP 8'h04
`define OFS_FLASH_CTRL 8'h08
`define OFS_FLASH_READ 8'h0C
`define OFS_PROC_MODE1 8'h10
`define OFS_ADC_CTRL 8'h14
`define OFS_DAC_CTRL 8'h18
`define OFS_DAC_VALUE0 8'h1C
`define OFS_MODE_REQ 8'h24
`define OFS_STATUS 8'h28

// ==========================================================
// Field positions
`define BIT_WAIT_GATE 2
`define BIT_CPU_SEL 7
`define BIT_CSP 7
`define BIT_REWRITE 1
`define BIT_FSTOP 3
`define BIT_SLOW 2
`define BIT_LOWCUR 3
`define BIT_ONE_WAIT 7
`define BIT_ADC_STBY 5
`define BIT_DAC_EN_LSB 0
`define DAC_CH 2
`define DAC_W 8

// ==========================================================
// Reset values and request codes
`define RST_BIT 1'b0
`define RST_DAC_VALUE 8'h00
`define REQ_WAIT 2'h1
`define REQ_STOP 2'h2

// ==========================================================
// Timing
`define CLK_MHZ 100
`define FLASH_STAB_NS 5000
`define FLASH_STAB_CYC ((`FLASH_STAB_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** rtl/lpm_pkg.sv ***
`default_nettype none
package lpm_pkg;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_WAIT, MODE_STOP} mode_t;
endpackage
`default_nettype wire

// *** rtl/pm_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pm_if;
    lpm_pkg::mode_t mode;
    logic wait_gate;
    logic csp;
    logic flash_stop;
    logic stab_done;
    modport ctl (output mode, wait_gate, csp, flash_stop, input stab_done);
    modport gate (input mode, wait_gate, csp);
    modport timer (input flash_stop, output stab_done);
endinterface
`default_nettype wire

// *** rtl/clock_gate_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_gate_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    pm_if.gate pm,
    output logic cpu_clk_en,
    output logic wdt_clk_en,
    output logic nmi_filter_clk_en,
    output logic main_periph_clk_en,
    output logic onchip_osc_clk_en,
    output logic sub_clk_en,
    output logic osc_run,
    output logic ext_periph_en,
    output logic port_hold
);
    // ==========================================================
    // Enable decode
    wire is_normal = (pm.mode == lpm_pkg::MODE_NORMAL);
    wire is_wait = (pm.mode == lpm_pkg::MODE_WAIT);
    wire cpu_next = is_normal;
    wire wdt_next = is_normal | (is_wait & pm.csp);
    wire main_next = is_normal | (is_wait & ~pm.wait_gate);
    wire osc_next = is_normal | is_wait;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en <= 1'b1;
            wdt_clk_en <= 1'b1;
            nmi_filter_clk_en <= 1'b1;
            main_periph_clk_en <= 1'b1;
            onchip_osc_clk_en <= 1'b1;
            sub_clk_en <= 1'b1;
            osc_run <= 1'b1;
            ext_periph_en <= 1'b0;
            port_hold <= 1'b0;
        end else begin
            cpu_clk_en <= cpu_next;
            wdt_clk_en <= wdt_next;
            nmi_filter_clk_en <= cpu_next;
            main_periph_clk_en <= main_next;
            onchip_osc_clk_en <= osc_next;
            sub_clk_en <= osc_next;
            osc_run <= osc_next;
            // External event paths never need an internal clock
            ext_periph_en <= 1'b1;
            port_hold <= ~is_normal;
        end
    end

    // ==========================================================
    // Checks
    wait_cpu_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_wait |=> !cpu_clk_en && !nmi_filter_clk_en && (wdt_clk_en == $past(pm.csp)))
        else $error("CPU clock not stopped in wait");
    wdt_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_wait && pm.csp |=> wdt_clk_en && !cpu_clk_en)
        else $error("Watchdog halted under protection");
    wait_osc_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_wait |=> osc_run && sub_clk_en && onchip_osc_clk_en)
        else $error("Oscillator stopped in wait");
    wait_gate_f1_a: assert property (@(posedge pclk) disable iff (!presetn)
        is_wait |=> (main_periph_clk_en == !$past(pm.wait_gate)) && sub_clk_en)
        else $error("Main peripheral clock gate wrong");
    stop_all_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        pm.mode == lpm_pkg::MODE_STOP |=> !osc_run && !cpu_clk_en && !wdt_clk_en
            && !main_periph_clk_en && !sub_clk_en && !onchip_osc_clk_en)
        else $error("Clock running in stop");
    stop_ext_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        pm.mode == lpm_pkg::MODE_STOP ##1 pm.mode == lpm_pkg::MODE_STOP |-> ext_periph_en)
        else $error("External path off in stop");
    port_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !is_normal |=> port_hold)
        else $error("Ports not held in low power");
endmodule
`default_nettype wire

// *** rtl/flash_restart_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_restart_timer #(
    parameter int STAB_CYCLES = 500
) (
    input wire logic pclk,
    input wire logic presetn,
    pm_if.timer pm
);
    localparam int CW = $clog2(STAB_CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(STAB_CYCLES);

    generate
        if (STAB_CYCLES < 1) begin : g_bad
            $error("STAB_CYCLES must be at least 1");
        end
    endgenerate

    // ==========================================================
    // Elapsed time since flash stop was set
    logic [CW-1:0] cnt_reg;
    logic done_reg;
    wire reached = (cnt_reg == LIMIT);
    wire [CW-1:0] cnt_next = !pm.flash_stop ? '0 : (reached ? cnt_reg : cnt_reg + 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            done_reg <= pm.flash_stop & reached;
        end
    end
    assign pm.stab_done = done_reg;

    stab_early_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pm.flash_stop) |-> !done_reg ##1 (!done_reg || !pm.flash_stop))
        else $error("Restart allowed too early");
    stab_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pm.flash_stop |=> !done_reg)
        else $error("Restart flag stuck after flash restart");
endmodule
`default_nettype wire

// *** rtl/low_power_mode_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module low_power_mode_control #(
    parameter int ADDR_W = 8,
    parameter int STAB_CYCLES = `FLASH_STAB_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_in,
    output logic cpu_clk_en,
    output logic wdt_clk_en,
    output logic nmi_filter_clk_en,
    output logic main_periph_clk_en,
    output logic onchip_osc_clk_en,
    output logic sub_clk_en,
    output logic osc_run,
    output logic ext_periph_en,
    output logic port_hold,
    output logic [1:0] power_mode,
    output logic flash_stop,
    output logic flash_rewrite_en,
    output logic flash_slow_read,
    output logic flash_low_current,
    output logic flash_one_wait,
    output logic cpu_on_sub_clock,
    output logic flash_restart_ok,
    output logic adc_standby,
    output logic [`DAC_CH-1:0] dac_output_en,
    output logic [`DAC_CH*`DAC_W-1:0] dac_value
);
    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("ADDR_W must be at least 8");
        end
    endgenerate

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [31:0] place(input logic v, input int pos);
        place = {31'h0, v} << pos;
    endfunction

    // ==========================================================
    // APB slave: one wait state, answer registered
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    wire access = psel & penable;
    wire fire = access & pready_reg;
    wire wr_en = fire & pwrite;
    wire [7:0] a8 = paddr[7:0];
    wire hi_zero = (ADDR_W == 8) ? 1'b1 : (paddr >> 8) == '0;

    wire sel_clk0 = hi_zero & hit(a8, `OFS_CLK_CTRL0);
    wire sel_csp = hi_zero & hit(a8, `OFS_CSP);
    wire sel_fctl = hi_zero & hit(a8, `OFS_FLASH_CTRL);
    wire sel_fread = hi_zero & hit(a8, `OFS_FLASH_READ);
    wire sel_pm1 = hi_zero & hit(a8, `OFS_PROC_MODE1);
    wire sel_adc = hi_zero & hit(a8, `OFS_ADC_CTRL);
    wire sel_dac = hi_zero & hit(a8, `OFS_DAC_CTRL);
    wire sel_req = hi_zero & hit(a8, `OFS_MODE_REQ);
    wire sel_stat = hi_zero & hit(a8, `OFS_STATUS);
    logic [`DAC_CH-1:0] sel_dval;
    genvar ch;
    generate
        for (ch = 0; ch < `DAC_CH; ch++) begin : g_dsel
            assign sel_dval[ch] = hi_zero & hit(a8, 8'(`OFS_DAC_VALUE0 + 4 * ch));
        end
    endgenerate
    wire mapped = sel_clk0 | sel_csp | sel_fctl | sel_fread | sel_pm1 | sel_adc
        | sel_dac | sel_req | sel_stat | (|sel_dval);

    // ==========================================================
    // Control registers
    logic wait_periph_clock_gate_bit_reg;
    logic cpu_clock_select_bit_reg;
    logic count_source_protect_bit_reg;
    logic cpu_rewrite_enable_bit_reg;
    logic flash_stop_bit_reg;
    logic slow_read_enable_bit_reg;
    logic low_current_read_enable_bit_reg;
    logic one_wait_bit_reg;
    logic adc_standby_bit_reg;
    logic [`DAC_CH-1:0] dac_output_enable_bit_reg;
    logic [`DAC_W-1:0] dac_value_reg [`DAC_CH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_periph_clock_gate_bit_reg <= `RST_BIT;
            cpu_clock_select_bit_reg <= `RST_BIT;
            count_source_protect_bit_reg <= `RST_BIT;
            one_wait_bit_reg <= `RST_BIT;
            adc_standby_bit_reg <= `RST_BIT;
            dac_output_enable_bit_reg <= '0;
        end else if (wr_en) begin
            if (sel_clk0) begin
                wait_periph_clock_gate_bit_reg <= pwdata[`BIT_WAIT_GATE];
                cpu_clock_select_bit_reg <= pwdata[`BIT_CPU_SEL];
            end
            if (sel_csp) count_source_protect_bit_reg <= pwdata[`BIT_CSP];
            if (sel_pm1) one_wait_bit_reg <= pwdata[`BIT_ONE_WAIT];
            if (sel_adc) adc_standby_bit_reg <= pwdata[`BIT_ADC_STBY];
            if (sel_dac) dac_output_enable_bit_reg <= pwdata[`BIT_DAC_EN_LSB +: `DAC_CH];
        end
    end

    // Flash bits are stored as written; software owns the interlocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_rewrite_enable_bit_reg <= `RST_BIT;
            flash_stop_bit_reg <= `RST_BIT;
            slow_read_enable_bit_reg <= `RST_BIT;
            low_current_read_enable_bit_reg <= `RST_BIT;
        end else if (wr_en) begin
            if (sel_fctl) begin
                cpu_rewrite_enable_bit_reg <= pwdata[`BIT_REWRITE];
                flash_stop_bit_reg <= pwdata[`BIT_FSTOP];
            end
            if (sel_fread) begin
                slow_read_enable_bit_reg <= pwdata[`BIT_SLOW];
                low_current_read_enable_bit_reg <= pwdata[`BIT_LOWCUR];
            end
        end
    end

    generate
        for (ch = 0; ch < `DAC_CH; ch++) begin : g_dval
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dac_value_reg[ch] <= `RST_DAC_VALUE;
                end else if (wr_en && sel_dval[ch]) begin
                    dac_value_reg[ch] <= pwdata[`DAC_W-1:0];
                end
            end
            assign dac_value[ch*`DAC_W +: `DAC_W] = dac_value_reg[ch];
        end
    endgenerate

    // ==========================================================
    // Wake input synchroniser
    logic wake_meta_reg;
    logic wake_sync_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= wake_in;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // ==========================================================
    // Power mode sequencer
    lpm_pkg::mode_t mode_reg;
    lpm_pkg::mode_t mode_next;
    wire req_wait = wr_en & sel_req & (pwdata[1:0] == `REQ_WAIT);
    wire req_stop = wr_en & sel_req & (pwdata[1:0] == `REQ_STOP);

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            lpm_pkg::MODE_NORMAL: begin
                if (req_stop) begin
                    mode_next = lpm_pkg::MODE_STOP;
                end else if (req_wait) begin
                    mode_next = lpm_pkg::MODE_WAIT;
                end
            end
            lpm_pkg::MODE_WAIT, lpm_pkg::MODE_STOP: begin
                if (wake_sync_reg) begin
                    mode_next = lpm_pkg::MODE_NORMAL;
                end
            end
            default: mode_next = lpm_pkg::MODE_NORMAL;
        endcase
    end

    logic [1:0] power_mode_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= lpm_pkg::MODE_NORMAL;
            power_mode_reg <= 2'h0;
        end else begin
            mode_reg <= mode_next;
            power_mode_reg <= 2'(mode_reg);
        end
    end

    // ==========================================================
    // Clock gating and flash timer
    pm_if pm ();
    assign pm.mode = mode_reg;
    assign pm.wait_gate = wait_periph_clock_gate_bit_reg;
    assign pm.csp = count_source_protect_bit_reg;
    assign pm.flash_stop = flash_stop_bit_reg;

    clock_gate_ctrl u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .pm(pm),
        .cpu_clk_en(cpu_clk_en),
        .wdt_clk_en(wdt_clk_en),
        .nmi_filter_clk_en(nmi_filter_clk_en),
        .main_periph_clk_en(main_periph_clk_en),
        .onchip_osc_clk_en(onchip_osc_clk_en),
        .sub_clk_en(sub_clk_en),
        .osc_run(osc_run),
        .ext_periph_en(ext_periph_en),
        .port_hold(port_hold)
    );

    flash_restart_timer #(.STAB_CYCLES(STAB_CYCLES)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .pm(pm)
    );

    // ==========================================================
    // Read mux and answer
    wire [31:0] stat_word = {25'h0, osc_run, wdt_clk_en, main_periph_clk_en,
        cpu_clk_en, pm.stab_done, power_mode_reg};
    logic [31:0] dval_word;
    always_comb begin
        dval_word = 32'h0;
        for (int i = 0; i < `DAC_CH; i++) begin
            if (sel_dval[i]) dval_word = {24'h0, dac_value_reg[i]};
        end
    end
    wire [31:0] rd_data =
        sel_clk0 ? (place(wait_periph_clock_gate_bit_reg, `BIT_WAIT_GATE)
            | place(cpu_clock_select_bit_reg, `BIT_CPU_SEL)) :
        sel_csp ? place(count_source_protect_bit_reg, `BIT_CSP) :
        sel_fctl ? (place(cpu_rewrite_enable_bit_reg, `BIT_REWRITE)
            | place(flash_stop_bit_reg, `BIT_FSTOP)) :
        sel_fread ? (place(slow_read_enable_bit_reg, `BIT_SLOW)
            | place(low_current_read_enable_bit_reg, `BIT_LOWCUR)) :
        sel_pm1 ? place(one_wait_bit_reg, `BIT_ONE_WAIT) :
        sel_adc ? place(adc_standby_bit_reg, `BIT_ADC_STBY) :
        sel_dac ? ({30'h0, dac_output_enable_bit_reg} << `BIT_DAC_EN_LSB) :
        sel_stat ? stat_word : dval_word;

    // Registered answer costs a wait state but keeps outputs glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~mapped;
            prdata_reg <= (access & ~pready_reg & ~pwrite & mapped) ? rd_data : 32'h0;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;
    assign power_mode = power_mode_reg;
    assign flash_stop = flash_stop_bit_reg;
    assign flash_rewrite_en = cpu_rewrite_enable_bit_reg;
    assign flash_slow_read = slow_read_enable_bit_reg;
    assign flash_low_current = low_current_read_enable_bit_reg;
    assign flash_one_wait = one_wait_bit_reg;
    assign cpu_on_sub_clock = cpu_clock_select_bit_reg;
    assign flash_restart_ok = pm.stab_done;
    assign adc_standby = adc_standby_bit_reg;
    assign dac_output_en = dac_output_enable_bit_reg;

    // ==========================================================
    // Checks
    mode_report_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 power_mode_reg == 2'($past(mode_reg)))
        else $error("Reported mode lags wrongly");
    wait_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == lpm_pkg::MODE_NORMAL && req_wait && !req_stop
            |=> mode_reg == lpm_pkg::MODE_WAIT ##1 !cpu_clk_en)
        else $error("Wait request not taken");
    stop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == lpm_pkg::MODE_NORMAL && req_stop
            |=> mode_reg == lpm_pkg::MODE_STOP ##1 !osc_run && port_hold)
        else $error("Stop request not taken");
    wake_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg != lpm_pkg::MODE_NORMAL && wake_sync_reg
            |=> mode_reg == lpm_pkg::MODE_NORMAL ##1 cpu_clk_en && osc_run)
        else $error("Wake did not restore normal mode");
endmodule
`default_nettype wire

// *** rtl/placeholder_never.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module tb;
    // ==========================================================
    // Clock, reset and design
    localparam int STAB = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] en_vec;
    logic [1:0] power_mode;
    logic [`DAC_CH-1:0] dac_output_en;
    logic [`DAC_CH*`DAC_W-1:0] dac_value;
    logic cpu, wdt, nmi, mainp, onchip, sub, osc, ext, hold;
    logic fstop, frw, fslow, flow, fwait, csub, fok, adc;
    int num_errors = 0;
    int checks = 0;
    assign en_vec = {cpu, wdt, nmi, mainp, onchip, sub, osc, ext, hold};
    low_power_mode_control #(.STAB_CYCLES(STAB)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_in(wake_in),
        .cpu_clk_en(cpu), .wdt_clk_en(wdt), .nmi_filter_clk_en(nmi),
        .main_periph_clk_en(mainp), .onchip_osc_clk_en(onchip), .sub_clk_en(sub),
        .osc_run(osc), .ext_periph_en(ext), .port_hold(hold), .power_mode(power_mode),
        .flash_stop(fstop), .flash_rewrite_en(frw), .flash_slow_read(fslow),
        .flash_low_current(flow), .flash_one_wait(fwait), .cpu_on_sub_clock(csub),
        .flash_restart_ok(fok), .adc_standby(adc), .dac_output_en(dac_output_en),
        .dac_value(dac_value));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Holds the request until pready is sampled high; slave latency is not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // Mode entry: enables land one edge after the completing write edge
    task automatic enter(input logic [31:0] code, input logic [8:0] exp, input logic [1:0] pm);
        wr(`OFS_MODE_REQ, code);
        repeat (2) @(posedge pclk);
        #1;
        chk("enables", {23'h0, exp}, {23'h0, en_vec});
        chk("power_mode", {30'h0, pm}, {30'h0, power_mode});
    endtask
    task automatic leave();
        int n;
        n = 0;
        @(posedge pclk);
        wake_in <= 1'b1;
        while (power_mode !== 2'h0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        #1;
        chk("wake enables", 32'h1FE, {23'h0, en_vec});
        @(posedge pclk);
        wake_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h0C, 8'h08};
        logic [31:0] msk [9] = '{32'h84, 32'h80, 32'h80, 32'h20, 32'h03, 32'hFF, 32'hFF,
                                  32'h0C, 32'h0A};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, adr[i], 32'h0, r, e);
            chk("reset value", 32'h0, r);
            // Low-current read only via slow read, and dropped before flash stop
            if (adr[i] == 8'h0C || adr[i] == 8'h08) wr(8'h0C, 32'h04);
            wr(adr[i], 32'hFFFFFFFF);
            apb(1'b0, adr[i], 32'h0, r, e);
            chk("readback", msk[i], r);
            chk("slverr", 32'h0, {31'h0, e});
        end
        chk("flash outs", 32'h77, {25'h0, fstop, frw, fslow, flow, fwait, csub, adc});
        chk("dac outs", 32'h3FFFF, {14'h0, dac_output_en, dac_value});
        // Flash stop stays set for the stabilisation time before restart
        repeat (STAB + 2) @(posedge pclk);
        for (int i = 8; i >= 0; i--) wr(adr[i], 32'h0);
        chk("dac cleared", 32'h0, {14'h0, dac_output_en, dac_value});
        chk("adc standby", 32'h0, {31'h0, adc});
        apb(1'b0, 8'h2C, 32'h0, r, e);
        chk("unmapped slverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        $display("Test registers done");
    endtask
    task automatic t_wait();
        logic [31:0] r;
        logic e;
        wr(`OFS_CLK_CTRL0, 32'h04);
        enter(32'h3, 9'h1FE, 2'h0);
        enter(`REQ_WAIT, 9'h01F, 2'h1);
        apb(1'b0, `OFS_STATUS, 32'h0, r, e);
        chk("status", 32'h41, r & 32'h7B);
        enter(`REQ_STOP, 9'h01F, 2'h1);
        leave();
        wr(`OFS_CLK_CTRL0, 32'h00);
        wr(`OFS_CSP, 32'h80);
        enter(`REQ_WAIT, 9'h0BF, 2'h1);
        leave();
        $display("Test wait mode done");
    endtask
    task automatic t_stop();
        enter(`REQ_STOP, 9'h003, 2'h2);
        leave();
        wr(`OFS_CSP, 32'h00);
        $display("Test stop mode done");
    endtask
    task automatic t_flash();
        logic [31:0] r;
        logic e;
        wr(`OFS_FLASH_CTRL, 32'h08);
        repeat (2) @(posedge pclk);
        #1;
        chk("restart early", 32'h0, {31'h0, fok});
        repeat (STAB + 2) @(posedge pclk);
        #1;
        chk("restart ok", 32'h1, {31'h0, fok});
        apb(1'b0, `OFS_STATUS, 32'h0, r, e);
        chk("status ok", 32'h4, r & 32'h4);
        wr(`OFS_FLASH_CTRL, 32'h00);
        repeat (2) @(posedge pclk);
        #1;
        chk("restart drop", 32'h0, {31'h0, fok});
        $display("Test flash restart done");
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_in = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("after reset", 32'h1FE, {23'h0, en_vec});
        t_regs();
        t_wait();
        t_stop();
        t_flash();
        stop_test();
    end
    // Generous bound: the full sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
